// ### logic/fis_params.svh
// Offsets, bit positions and reset values of the fault and interrupt status registers.
// Assumes an 8-bit register address and 8-bit register data on the control port.
`ifndef FIS_PARAMS_SVH
`define FIS_PARAMS_SVH

`define FIS_ADDR_W              8
`define FIS_DATA_W              8

`define FIS_OFS_LATCHED         8'h3B
`define FIS_OFS_LIVE            8'h3C
`define FIS_OFS_SUMMARY         8'h3D

`define FIS_RST_LATCHED         8'h00
`define FIS_RST_LIVE            8'h00
`define FIS_RST_SUMMARY         8'h00
`define FIS_RDATA_UNMAPPED      8'h00

`define FIS_LAT_ANALOG_HIGH     7
`define FIS_LAT_ANALOG_LOW      6
`define FIS_LAT_VOICE_UP        5
`define FIS_LAT_VOICE_DOWN      4
`define FIS_LAT_BIAS_SHORT      3
`define FIS_LAT_BIAS_HI_CUR     2
`define FIS_LAT_BIAS_LO_CUR     1
`define FIS_LAT_BIAS_OVER_V     0

`define FIS_LIVE_CLK_ERR        7
`define FIS_LIVE_PLL_LOCK       6
`define FIS_LIVE_BOOST_TEMP     5
`define FIS_LIVE_BOOST_CUR      4
`define FIS_LIVE_BOOST_MODE     3
`define FIS_LIVE_EVENTS         5

`define FIS_SUM_IN1             7
`define FIS_SUM_IN2             6
`define FIS_SUM_OUT1            5
`define FIS_SUM_OUT2            4
`define FIS_SUM_VBAT_LT_BIAS    3

`define FIS_RSVD_MSB            2
`define FIS_RSVD_RST            3'h0

`define FIS_IN_DETAIL_W         8
`define FIS_OUT_DETAIL_W        4
`define FIS_CHANNELS            4

`endif

// ### logic/fis_pkg.sv
// Types shared by the fault and interrupt status block.
// Numeric constants live in fis_params.svh.
package fis_pkg;

    typedef logic [7:0] fis_byte_t;
    typedef logic [7:0] fis_addr_t;

    typedef enum logic [1:0] {
        FIS_SEL_LATCHED,
        FIS_SEL_LIVE,
        FIS_SEL_SUMMARY,
        FIS_SEL_NONE
    } fis_reg_sel_t;

endpackage

// ### logic/fis_sync.sv
// Three-stage synchroniser for a group of asynchronous level inputs.
// Assumes the inputs are levels held far longer than three clock periods.
`timescale 1ns/1ns

module fis_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             core_clk,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] stage1_q;
    logic [WIDTH-1:0] stage2_q;
    logic [WIDTH-1:0] stage3_q;
    logic [WIDTH-1:0] agree;

    // A bit changes only once the last two stages agree, so a metastable
    // settle in stage one never reaches the register file.
    assign agree = ~(stage2_q ^ stage3_q);

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            stage1_q <= '0;
            stage2_q <= '0;
            stage3_q <= '0;
            sync_out <= '0;
        end else begin
            stage1_q <= async_in;
            stage2_q <= stage1_q;
            stage3_q <= stage2_q;
            sync_out <= (agree & stage3_q) | (~agree & sync_out);
        end
    end

endmodule

// ### logic/fis_status.sv
// Fault and interrupt status registers: latched bias and voice-activity events,
// live clock and boost events, and the per-channel fault summary.
// Assumes the control-port decoder hands over one-cycle read and write strobes
// with an 8-bit address; all fault sources are asynchronous analog levels.
`timescale 1ns/1ns
`include "fis_params.svh"

module fis_status #(
    parameter int IN_DETAIL_W  = `FIS_IN_DETAIL_W,
    parameter int OUT_DETAIL_W = `FIS_OUT_DETAIL_W,
    parameter int CHANNELS     = `FIS_CHANNELS
) (
    input  wire logic                    core_clk,
    input  wire logic                    rst_n,
    // Register access from the control port
    input  wire logic                    reg_rd,
    input  wire logic                    reg_wr,
    input  wire fis_pkg::fis_addr_t      reg_addr,
    input  wire fis_pkg::fis_byte_t      reg_wdata,
    output fis_pkg::fis_byte_t           reg_rdata,
    output logic                         reg_rvalid,
    output logic                         reg_hit,
    output logic                         reg_wr_rsvd_err,
    // Latched event sources
    input  wire logic                    analog_above_high,
    input  wire logic                    analog_below_low,
    input  wire logic                    voice_power_up,
    input  wire logic                    voice_power_down,
    input  wire logic                    bias_short,
    input  wire logic                    bias_high_current,
    input  wire logic                    bias_low_current,
    input  wire logic                    bias_over_voltage,
    // Live event sources
    input  wire logic                    clock_error,
    input  wire logic                    pll_locked,
    input  wire logic                    boost_over_temp,
    input  wire logic                    boost_over_current,
    input  wire logic                    boost_mode_event,
    // Detailed live channel faults
    input  wire logic [IN_DETAIL_W-1:0]  in1_detail,
    input  wire logic [IN_DETAIL_W-1:0]  in2_detail,
    input  wire logic [OUT_DETAIL_W-1:0] out1_detail,
    input  wire logic [OUT_DETAIL_W-1:0] out2_detail,
    input  wire logic [CHANNELS-1:0]     vbat_short_lt_bias,
    // Latched, live and summary register values for neighbouring blocks
    output fis_pkg::fis_byte_t           latched_events,
    output fis_pkg::fis_byte_t           live_events,
    output fis_pkg::fis_byte_t           fault_summary
);

    import fis_pkg::*;

    localparam int LAT_W  = `FIS_DATA_W;
    localparam int LIVE_W = `FIS_LIVE_EVENTS;
    localparam int DET_W  = 2 * IN_DETAIL_W + 2 * OUT_DETAIL_W + CHANNELS;

    // Synchronised sources
    logic [LAT_W-1:0]  lat_src_raw;
    logic [LAT_W-1:0]  lat_src;
    logic [LIVE_W-1:0] live_src_raw;
    logic [LIVE_W-1:0] live_src;
    logic [DET_W-1:0]  det_src_raw;
    logic [DET_W-1:0]  det_src;

    logic [IN_DETAIL_W-1:0]  in1_s;
    logic [IN_DETAIL_W-1:0]  in2_s;
    logic [OUT_DETAIL_W-1:0] out1_s;
    logic [OUT_DETAIL_W-1:0] out2_s;
    logic [CHANNELS-1:0]     vbat_s;

    // Register state
    fis_byte_t    latched_q;
    fis_byte_t    latched_d;
    fis_byte_t    live_q;
    fis_byte_t    live_d;
    fis_byte_t    summary_q;
    fis_byte_t    summary_d;
    fis_byte_t    rdata_q;
    fis_byte_t    rdata_d;
    logic         rvalid_q;
    logic         wr_err_q;

    // Decode
    fis_reg_sel_t sel;
    logic         hit_latched;
    logic         hit_live;
    logic         hit_summary;
    logic         rd_latched;
    logic         clr_en;
    fis_byte_t    clr_mask;
    fis_byte_t    set_mask;
    logic         wr_rsvd_bad;

    // Source packing
    always_comb begin
        lat_src_raw                          = '0;
        lat_src_raw[`FIS_LAT_ANALOG_HIGH]    = analog_above_high;
        lat_src_raw[`FIS_LAT_ANALOG_LOW]     = analog_below_low;
        lat_src_raw[`FIS_LAT_VOICE_UP]       = voice_power_up;
        lat_src_raw[`FIS_LAT_VOICE_DOWN]     = voice_power_down;
        lat_src_raw[`FIS_LAT_BIAS_SHORT]     = bias_short;
        lat_src_raw[`FIS_LAT_BIAS_HI_CUR]    = bias_high_current;
        lat_src_raw[`FIS_LAT_BIAS_LO_CUR]    = bias_low_current;
        lat_src_raw[`FIS_LAT_BIAS_OVER_V]    = bias_over_voltage;
    end

    assign live_src_raw = {clock_error,
                           pll_locked,
                           boost_over_temp,
                           boost_over_current,
                           boost_mode_event};

    assign det_src_raw = {in1_detail,
                          in2_detail,
                          out1_detail,
                          out2_detail,
                          vbat_short_lt_bias};

    fis_sync #(
        .WIDTH (LAT_W)
    ) u_sync_lat (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .async_in (lat_src_raw),
        .sync_out (lat_src)
    );

    fis_sync #(
        .WIDTH (LIVE_W)
    ) u_sync_live (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .async_in (live_src_raw),
        .sync_out (live_src)
    );

    fis_sync #(
        .WIDTH (DET_W)
    ) u_sync_det (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .async_in (det_src_raw),
        .sync_out (det_src)
    );

    assign {in1_s, in2_s, out1_s, out2_s, vbat_s} = det_src;

    // Address decode
    assign hit_latched = (reg_addr == `FIS_OFS_LATCHED);
    assign hit_live    = (reg_addr == `FIS_OFS_LIVE);
    assign hit_summary = (reg_addr == `FIS_OFS_SUMMARY);

    assign sel = hit_latched ? FIS_SEL_LATCHED :
                 hit_live    ? FIS_SEL_LIVE    :
                 hit_summary ? FIS_SEL_SUMMARY : FIS_SEL_NONE;

    assign reg_hit = (reg_rd | reg_wr) & (sel != FIS_SEL_NONE);

    // Latched events: a source level keeps its flag set; a read clears only
    // the bits it returned, and a source still active sets it again at once,
    // so an event coinciding with the read is never lost.
    assign rd_latched = reg_rd & hit_latched;
    assign clr_en     = rd_latched;
    assign clr_mask   = clr_en ? latched_q : `FIS_RST_LATCHED;
    assign set_mask   = lat_src;
    assign latched_d  = (latched_q & ~clr_mask) | set_mask;

    // Live events track their sources; reads have no side effect.
    always_comb begin
        live_d                           = `FIS_RST_LIVE;
        live_d[`FIS_LIVE_CLK_ERR]        = live_src[4];
        live_d[`FIS_LIVE_PLL_LOCK]       = live_src[3];
        live_d[`FIS_LIVE_BOOST_TEMP]     = live_src[2];
        live_d[`FIS_LIVE_BOOST_CUR]      = live_src[1];
        live_d[`FIS_LIVE_BOOST_MODE]     = live_src[0];
        live_d[`FIS_RSVD_MSB:0]          = `FIS_RSVD_RST;
    end

    // Channel summary is an unlatched OR of the detail bits.
    always_comb begin
        summary_d                        = `FIS_RST_SUMMARY;
        summary_d[`FIS_SUM_IN1]          = |in1_s;
        summary_d[`FIS_SUM_IN2]          = |in2_s;
        summary_d[`FIS_SUM_OUT1]         = |out1_s;
        summary_d[`FIS_SUM_OUT2]         = |out2_s;
        summary_d[`FIS_SUM_VBAT_LT_BIAS] = |vbat_s;
        summary_d[`FIS_RSVD_MSB:0]       = `FIS_RSVD_RST;
    end

    // Read mux: the value returned for the latched register is the one that
    // the same edge clears, so software sees exactly what it acknowledged.
    always_comb begin
        unique case (sel)
            FIS_SEL_LATCHED: rdata_d = latched_q;
            FIS_SEL_LIVE:    rdata_d = live_q;
            FIS_SEL_SUMMARY: rdata_d = summary_q;
            FIS_SEL_NONE:    rdata_d = `FIS_RDATA_UNMAPPED;
        endcase
    end

    // All three registers are read-only; a write that puts anything other
    // than the reset value into a reserved field is flagged for one cycle.
    assign wr_rsvd_bad = reg_wr
                         & (hit_live | hit_summary)
                         & (reg_wdata[`FIS_RSVD_MSB:0] != `FIS_RSVD_RST);

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            latched_q <= `FIS_RST_LATCHED;
            live_q    <= `FIS_RST_LIVE;
            summary_q <= `FIS_RST_SUMMARY;
        end else begin
            latched_q <= latched_d;
            live_q    <= live_d;
            summary_q <= summary_d;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            rdata_q  <= `FIS_RDATA_UNMAPPED;
            rvalid_q <= 1'b0;
            wr_err_q <= 1'b0;
        end else begin
            rvalid_q <= reg_rd;
            wr_err_q <= wr_rsvd_bad;
            if (reg_rd) begin
                rdata_q <= rdata_d;
            end
        end
    end

    assign reg_rdata       = rdata_q;
    assign reg_rvalid      = rvalid_q;
    assign reg_wr_rsvd_err = wr_err_q;
    assign latched_events  = latched_q;
    assign live_events     = live_q;
    assign fault_summary   = summary_q;

endmodule

// ### sim/fis_status_properties.sv
// Port checks for the fault and interrupt status block.
// Assumes one core_clk domain and a synchronous active-low rst_n.
`timescale 1ns/1ns
`include "fis_params.svh"

module fis_status_properties (
    input wire logic               core_clk,
    input wire logic               rst_n,
    input wire logic               reg_rd,
    input wire logic               reg_wr,
    input wire fis_pkg::fis_addr_t reg_addr,
    input wire fis_pkg::fis_byte_t reg_wdata,
    input wire fis_pkg::fis_byte_t reg_rdata,
    input wire logic               reg_rvalid,
    input wire logic               reg_hit,
    input wire logic               reg_wr_rsvd_err,
    input wire fis_pkg::fis_byte_t latched_events,
    input wire fis_pkg::fis_byte_t live_events,
    input wire fis_pkg::fis_byte_t fault_summary
);
    import fis_pkg::*;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    wire at_lat  = reg_addr == `FIS_OFS_LATCHED;
    wire at_live = reg_addr == `FIS_OFS_LIVE;
    wire at_sum  = reg_addr == `FIS_OFS_SUMMARY;

    chk_rd_answer: assert property (reg_rd |=> reg_rvalid)
        else $error("read gave no rvalid");
    chk_rvalid_cause: assert property (reg_rvalid |-> $past(reg_rd))
        else $error("rvalid without read");
    chk_rd_latched: assert property (
        reg_rd && at_lat |=> reg_rdata == $past(latched_events))
        else $error("latched read data wrong");
    chk_rd_live: assert property (
        reg_rd && at_live |=> reg_rdata == $past(live_events))
        else $error("live read data wrong");
    chk_rd_summary: assert property (
        reg_rd && at_sum |=> reg_rdata == $past(fault_summary))
        else $error("summary read data wrong");
    chk_rsvd_zero: assert property (
        live_events[2:0] == 3'h0 && fault_summary[2:0] == 3'h0)
        else $error("reserved bits nonzero");
    // Without a read of the latched register no set bit may fall
    chk_latch_sticky: assert property (
        !(reg_rd && at_lat) |=> (~latched_events & $past(latched_events)) == 8'h00)
        else $error("latched bit lost without read");
    chk_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata))
        else $error("read data moved without read");
    chk_hit_decode: assert property (
        reg_hit == ((reg_rd || reg_wr) && (at_lat || at_live || at_sum)))
        else $error("hit decode wrong");
    chk_wr_rsvd: assert property (
        reg_wr && (at_live || at_sum) && reg_wdata[2:0] != 3'h0 |=> reg_wr_rsvd_err)
        else $error("reserved write not flagged");

    cover property (reg_rd && at_lat && latched_events != 8'h00);
    cover property (reg_wr_rsvd_err);
    cover property (fault_summary != 8'h00);
endmodule

// ### sim/fis_status_bench.sv
// Self-checking bench for the fault and interrupt status block.
// Assumes the offsets of fis_params.svh; sources are held as slow levels.
`timescale 1ns/1ns
`include "fis_params.svh"

module fis_status_bench;
    import fis_pkg::*;
    logic        core_clk  = 1'b0;
    logic        rst_n     = 1'b0;
    logic        reg_rd    = 1'b0;
    logic        reg_wr    = 1'b0;
    fis_addr_t   reg_addr  = 8'h00;
    fis_byte_t   reg_wdata = 8'h00;
    logic [7:0]  lat_src   = 8'h00;
    logic [4:0]  live_src  = 5'h00;
    logic [27:0] det_src   = 28'h000_0000;
    fis_byte_t   reg_rdata;
    fis_byte_t   latched_events;
    fis_byte_t   live_events;
    fis_byte_t   fault_summary;
    logic        reg_rvalid;
    logic        reg_hit;
    logic        reg_wr_rsvd_err;
    int          n_mismatch = 0;
    int          n_checks   = 0;

    fis_status DUT (.core_clk(core_clk), .rst_n(rst_n), .reg_rd(reg_rd), .reg_wr(reg_wr),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .reg_hit(reg_hit), .reg_wr_rsvd_err(reg_wr_rsvd_err),
        .analog_above_high(lat_src[7]), .analog_below_low(lat_src[6]),
        .voice_power_up(lat_src[5]), .voice_power_down(lat_src[4]),
        .bias_short(lat_src[3]), .bias_high_current(lat_src[2]),
        .bias_low_current(lat_src[1]), .bias_over_voltage(lat_src[0]),
        .clock_error(live_src[4]), .pll_locked(live_src[3]), .boost_over_temp(live_src[2]),
        .boost_over_current(live_src[1]), .boost_mode_event(live_src[0]),
        .in1_detail(det_src[7:0]), .in2_detail(det_src[15:8]), .out1_detail(det_src[19:16]),
        .out2_detail(det_src[23:20]), .vbat_short_lt_bias(det_src[27:24]),
        .latched_events(latched_events), .live_events(live_events),
        .fault_summary(fault_summary));

    always #5 core_clk = ~core_clk;

    task check(input fis_byte_t got, input fis_byte_t exp, input string what);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // Sources pass a synchroniser, so allow comfortably more than its 4 edges plus the register edge
    task settle;
        repeat (8) @(posedge core_clk);
    endtask

    // Both bus tasks return on a rising edge, so callers drive sources on it
    task rd(input fis_addr_t a, input fis_byte_t exp);
        logic hit_exp;
        hit_exp = a inside {8'h3B, 8'h3C, 8'h3D};
        @(posedge core_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        #1 check({7'h00, reg_hit}, {7'h00, hit_exp}, "hit");
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 check({7'h00, reg_rvalid}, 8'h01, "rvalid");
        check(reg_rdata, exp, "rdata");
        @(posedge core_clk);
    endtask

    task wr(input fis_addr_t a, input fis_byte_t d, input logic exp_err);
        @(posedge core_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        #1 check({7'h00, reg_wr_rsvd_err}, {7'h00, exp_err}, "write error flag");
        @(posedge core_clk);
    endtask

    task s_reset_values;
        rd(`FIS_OFS_LATCHED, 8'h00);
        rd(`FIS_OFS_LIVE, 8'h00);
        rd(`FIS_OFS_SUMMARY, 8'h00);
        rd(8'h3A, 8'h00);
    endtask

    task s_latched_bits;
        for (int i = 0; i < 8; i++) begin
            lat_src <= 8'h01 << i;
            settle;
            lat_src <= 8'h00;
            settle;
            check(latched_events, 8'h01 << i, "latched");
            rd(`FIS_OFS_LATCHED, 8'h01 << i);
            rd(`FIS_OFS_LATCHED, 8'h00);
        end
    endtask

    // Writes must neither clear a flag nor pass reserved bits unnoticed
    task s_writes_and_persist;
        lat_src <= 8'h09;
        settle;
        wr(`FIS_OFS_LATCHED, 8'hFF, 1'b0);
        wr(`FIS_OFS_LIVE, 8'h01, 1'b1);
        wr(`FIS_OFS_SUMMARY, 8'h04, 1'b1);
        wr(`FIS_OFS_SUMMARY, 8'hF8, 1'b0);
        rd(`FIS_OFS_LATCHED, 8'h09);
        rd(`FIS_OFS_LATCHED, 8'h09);
        lat_src <= 8'h00;
        settle;
        rd(`FIS_OFS_LATCHED, 8'h09);
        rd(`FIS_OFS_LATCHED, 8'h00);
    endtask

    task s_live_bits;
        for (int i = 0; i < 5; i++) begin
            live_src <= 5'h01 << i;
            settle;
            rd(`FIS_OFS_LIVE, 8'h08 << i);
            rd(`FIS_OFS_LIVE, 8'h08 << i);
            check(live_events, 8'h08 << i, "live port");
            live_src <= 5'h00;
            settle;
            rd(`FIS_OFS_LIVE, 8'h00);
        end
    endtask

    task s_summary_bits;
        fis_byte_t exp;
        for (int j = 0; j < 28; j++) begin
            exp = (j < 8) ? 8'h80 : (j < 16) ? 8'h40 : (j < 20) ? 8'h20 : (j < 24) ? 8'h10 : 8'h08;
            det_src <= 28'h000_0001 << j;
            settle;
            rd(`FIS_OFS_SUMMARY, exp);
            check(fault_summary, exp, "summary port");
            det_src <= 28'h000_0000;
            settle;
            rd(`FIS_OFS_SUMMARY, 8'h00);
        end
    endtask

    task finish_test;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    initial begin
        repeat (12) @(posedge core_clk);
        rst_n <= 1'b1;
        s_reset_values;
        s_latched_bits;
        s_writes_and_persist;
        s_live_bits;
        s_summary_bits;
        finish_test;
    end

    initial begin
        repeat (20000) @(posedge core_clk);
        n_mismatch++;
        $display("[FAIL] %0t watchdog expired", $time);
        finish_test;
    end
endmodule

bind fis_status fis_status_properties u_props (.core_clk(core_clk), .rst_n(rst_n),
    .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .reg_hit(reg_hit),
    .reg_wr_rsvd_err(reg_wr_rsvd_err), .latched_events(latched_events),
    .live_events(live_events), .fault_summary(fault_summary));
